// *** cascaded_timer_carrier_pwm.sv ***
// top: cascaded 8-bit timer pair with 16-bit count, carrier and pwm modes
`timescale 1ns/10ps
`default_nettype none
module cascaded_timer_carrier_pwm (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] mode_sel,
    input  wire logic [2:0] clock_select,
    input  wire logic       upper_run_enable,
    input  wire logic       lower_run_enable,
    input  wire logic       upper_output_enable,
    input  wire logic       lower_output_enable,
    input  wire logic [7:0] upper_compare,
    input  wire logic [7:0] lower_compare_low,
    input  wire logic [7:0] lower_compare_high,
    input  wire logic [7:0] ctl_wdata,
    input  wire logic       ctl_we,
    input  wire logic       event_input_pin,
    output logic [7:0]      ctl_rdata,
    output logic [7:0]      upper_counter,
    output logic [7:0]      lower_counter,
    output logic            upper_match_irq,
    output logic            lower_match_irq,
    output logic            lower_timer_output,
    output logic            lower_timer_output_oe,
    output logic            upper_timer_output,
    output logic            upper_timer_output_oe,
    output logic            compare_high_active
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] up_cnt;
        logic [7:0] lo_cnt;
        logic       lo_irq;
        logic       up_irq;
        logic       up_irq_last;
        logic       lo_tf;
        logic       up_tf;
        logic       sel_high;
        logic       remote_sel;
        logic       nrz_buf;
        logic       nrz_act;
    } core_state_t;

    core_state_t st_ff;
    core_state_t nxt_st;
    logic        event_sync;
    logic        is_cascade;
    logic        is_carrier;
    logic        lo_run;
    logic        up_run;
    logic        lo_match;
    logic        up_match;
    logic [7:0]  lo_cmp;
    logic [15:0] cnt16;
    logic        up_tick;

    tick_if tk_lo ();
    tick_if tk_up ();

    // ------------------------------------------------------------------
    // pin synchroniser and prescalers
    // ------------------------------------------------------------------
    tmr_sync u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (event_input_pin),
        .dout  (event_sync)
    );

    tmr_prescale u_pre_lo (
        .clk        (clk),
        .rst_n      (rst_n),
        .run        (lo_run),
        .clk_sel    (clock_select),
        .event_sync (event_sync),
        .tk         (tk_lo.src)
    );

    // upper timer in carrier mode has its own prescaler on the same select
    tmr_prescale u_pre_up (
        .clk        (clk),
        .rst_n      (rst_n),
        .run        (up_run),
        .clk_sel    (clock_select),
        .event_sync (event_sync),
        .tk         (tk_up.src)
    );

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    function automatic logic cmp_eq(input logic [7:0] a, input logic [7:0] b);
        cmp_eq = (a == b);
    endfunction

    assign is_cascade = (mode_sel == tmr_pkg::MODE_CASCADE);
    assign is_carrier = (mode_sel == tmr_pkg::MODE_CARRIER);
    assign lo_run     = is_carrier ? (lower_run_enable & upper_run_enable)
                                   : lower_run_enable;
    assign up_run     = is_carrier & upper_run_enable & lower_run_enable;
    assign lo_cmp     = st_ff.sel_high ? lower_compare_high : lower_compare_low;
    assign cnt16      = {st_ff.up_cnt, st_ff.lo_cnt};
    // compare zero is legal: counter sits at zero and matches on next pulse
    assign lo_match   = tk_lo.tick & cmp_eq(st_ff.lo_cnt, lo_cmp);
    assign up_match   = cmp_eq(st_ff.up_cnt, upper_compare);
    assign up_tick    = tk_up.tick;

    // ------------------------------------------------------------------
    // counters, outputs, nrz
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st             = st_ff;
        nxt_st.lo_irq      = 1'b0;
        nxt_st.up_irq      = 1'b0;
        nxt_st.up_irq_last = st_ff.up_irq;
        if (is_cascade) begin
            if (!lo_run) begin
                nxt_st.up_cnt = tmr_pkg::COUNT_RESET;
                nxt_st.lo_cnt = tmr_pkg::COUNT_RESET;
                nxt_st.lo_tf  = 1'b0;
            end else if (tk_lo.tick) begin
                if (cmp_eq(st_ff.lo_cnt, lower_compare_low) && up_match) begin
                    nxt_st.up_cnt = tmr_pkg::COUNT_RESET;
                    nxt_st.lo_cnt = tmr_pkg::COUNT_RESET;
                    nxt_st.lo_irq = 1'b1;
                    nxt_st.lo_tf  = ~st_ff.lo_tf;
                end else begin
                    {nxt_st.up_cnt, nxt_st.lo_cnt} = cnt16 + 16'h0001;
                end
            end
            nxt_st.sel_high = 1'b0;
        end else begin
            if (!lo_run) begin
                nxt_st.lo_cnt   = tmr_pkg::COUNT_RESET;
                nxt_st.lo_tf    = 1'b0;
                nxt_st.sel_high = 1'b0;
            end else if (lo_match) begin
                nxt_st.lo_cnt   = tmr_pkg::COUNT_RESET;
                nxt_st.lo_irq   = 1'b1;
                nxt_st.lo_tf    = ~st_ff.lo_tf;
                nxt_st.sel_high = ~st_ff.sel_high;
            end else if (tk_lo.tick) begin
                nxt_st.lo_cnt = st_ff.lo_cnt + 8'h01;
            end
            if (!is_carrier || !up_run) begin
                nxt_st.up_cnt = tmr_pkg::COUNT_RESET;
            end else if (up_tick) begin
                if (up_match) begin
                    nxt_st.up_cnt = tmr_pkg::COUNT_RESET;
                    nxt_st.up_irq = 1'b1;
                end else begin
                    nxt_st.up_cnt = st_ff.up_cnt + 8'h01;
                end
            end
        end
        // output low whenever disabled, so it starts low once enabled
        if (!lower_output_enable) begin
            nxt_st.lo_tf = 1'b0;
        end
        nxt_st.up_tf = 1'b0;
        // whole-byte control write; reload on irq rise wins for the active bit
        if (ctl_we) begin
            nxt_st.remote_sel = ctl_wdata[tmr_pkg::CTL_REMOTE_BIT];
            nxt_st.nrz_buf    = ctl_wdata[tmr_pkg::CTL_NRZBUF_BIT];
            nxt_st.nrz_act    = ctl_wdata[tmr_pkg::CTL_NRZACT_BIT];
        end else if (is_carrier && !up_run) begin
            nxt_st.nrz_buf = 1'b0;
        end
        if (st_ff.up_irq && !st_ff.up_irq_last) begin
            nxt_st.nrz_act = st_ff.nrz_buf;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_comb begin
        lower_timer_output = st_ff.lo_tf;
        if (is_carrier) begin
            // remote select one has no source here, so it reads as low
            lower_timer_output = st_ff.lo_tf & st_ff.nrz_act & ~st_ff.remote_sel;
        end
    end

    assign ctl_rdata             = {5'h00, st_ff.remote_sel, st_ff.nrz_buf, st_ff.nrz_act};
    assign upper_counter         = st_ff.up_cnt;
    assign lower_counter         = st_ff.lo_cnt;
    assign lower_match_irq       = st_ff.lo_irq;
    assign upper_match_irq       = st_ff.up_irq;
    assign lower_timer_output_oe = lower_output_enable;
    // upper pin unusable in cascade; held low everywhere
    assign upper_timer_output    = st_ff.up_tf;
    assign upper_timer_output_oe = upper_output_enable & ~is_cascade;
    assign compare_high_active   = st_ff.sel_high;
endmodule
`default_nettype wire

// *** tmr_pkg.sv ***
// package: mode codes, clock select codes, field positions and reset values of the timer pair
package tmr_pkg;
    localparam logic [1:0] MODE_CASCADE   = 2'h0;
    localparam logic [1:0] MODE_CARRIER   = 2'h1;
    localparam logic [1:0] MODE_PWM       = 2'h2;
    localparam logic [2:0] CLK_DIV4       = 3'h0;
    localparam logic [2:0] CLK_DIV8       = 3'h1;
    localparam logic [2:0] CLK_EXT        = 3'h2;
    localparam logic [2:0] CLK_EXT_DIV2   = 3'h3;
    localparam logic [2:0] CLK_EXT_DIV4   = 3'h4;
    localparam logic [2:0] CLK_EXT_DIV8   = 3'h5;
    localparam int         CTL_REMOTE_BIT = 2;
    localparam int         CTL_NRZBUF_BIT = 1;
    localparam int         CTL_NRZACT_BIT = 0;
    localparam logic [7:0] COUNT_RESET    = 8'h00;
    localparam logic [2:0] PRE_RESET      = 3'h0;
endpackage

// *** tick_if.sv ***
// interface: count tick from the prescaler to the counter core
`timescale 1ns/10ps
`default_nettype none
interface tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input  tick);
endinterface
`default_nettype wire

// *** tmr_prescale.sv ***
// prescaler: main clock or gated event input divided into a one-cycle count tick
`timescale 1ns/10ps
`default_nettype none
module tmr_prescale (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [2:0] clk_sel,
    input  wire logic       event_sync,
    tick_if.src             tk
);
    typedef struct packed {
        logic [2:0] div;
        logic [2:0] ext_div;
        logic       ev_last;
    } pre_state_t;

    pre_state_t st_ff;
    pre_state_t nxt_st;
    logic       ev_gated;
    logic       ev_edge;

    // pin is anded with run so a high pin at enable gives an immediate edge
    assign ev_gated = event_sync & run;
    assign ev_edge  = ev_gated & ~st_ff.ev_last;

    always_comb begin
        nxt_st         = st_ff;
        nxt_st.ev_last = ev_gated;
        tk.tick        = 1'b0;
        if (!run) begin
            // free phase restarts on enable: first tick comes one full division after run
            nxt_st.div     = tmr_pkg::PRE_RESET;
            nxt_st.ext_div = tmr_pkg::PRE_RESET;
        end else begin
            nxt_st.div = st_ff.div + 3'h1;
            if (ev_edge) begin
                nxt_st.ext_div = st_ff.ext_div + 3'h1;
            end
            case (clk_sel)
                tmr_pkg::CLK_DIV4:     tk.tick = (st_ff.div[1:0] == 2'h3);
                tmr_pkg::CLK_DIV8:     tk.tick = (st_ff.div == 3'h7);
                tmr_pkg::CLK_EXT:      tk.tick = ev_edge;
                tmr_pkg::CLK_EXT_DIV2: tk.tick = ev_edge & st_ff.ext_div[0];
                tmr_pkg::CLK_EXT_DIV4: tk.tick = ev_edge & (st_ff.ext_div[1:0] == 2'h3);
                tmr_pkg::CLK_EXT_DIV8: tk.tick = ev_edge & (st_ff.ext_div == 3'h7);
                default:               tk.tick = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule
`default_nettype wire

// *** tmr_sync.sv ***
// two-flop synchroniser for the event input pin
`timescale 1ns/10ps
`default_nettype none
module tmr_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_state_t;

    sync_state_t st_ff;
    sync_state_t nxt_st;

    always_comb begin
        nxt_st.s1 = din;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dout = st_ff.s2;
endmodule
`default_nettype wire

// *** cascaded_timer_carrier_pwm_sva.sv ***
// checker: port timing relations of the cascaded timer pair
`timescale 1ns/10ps
`default_nettype none
module cascaded_timer_carrier_pwm_sva (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [1:0] mode_sel,
    input wire logic       lower_run_enable,
    input wire logic       lower_output_enable,
    input wire logic [7:0] ctl_rdata,
    input wire logic [7:0] upper_counter,
    input wire logic [7:0] lower_counter,
    input wire logic       upper_match_irq,
    input wire logic       lower_match_irq,
    input wire logic       upper_timer_output_oe,
    input wire logic       lower_timer_output
);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic casc = mode_sel == tmr_pkg::MODE_CASCADE;
    wire logic carr = mode_sel == tmr_pkg::MODE_CARRIER;
    wire logic pwm  = mode_sel == tmr_pkg::MODE_PWM;
    // a steady run with the pin enabled, so only matches may move it
    sequence s_steady;
        casc && lower_run_enable && $past(lower_run_enable) && lower_output_enable;
    endsequence
    sequence s_reload;
        carr && $rose(upper_match_irq);
    endsequence
    a_no_upper_irq: assert property (casc |-> !upper_match_irq)
        else $error("upper irq raised in cascade mode");
    a_match_clears: assert property (casc && lower_match_irq |->
        upper_counter == 8'h00 && lower_counter == 8'h00)
        else $error("cascade match did not clear both counters");
    a_irq_one_cycle: assert property (lower_match_irq |=> !lower_match_irq)
        else $error("lower irq longer than one cycle");
    a_stop_clears: assert property (casc && !lower_run_enable |=>
        lower_counter == 8'h00 && upper_counter == 8'h00)
        else $error("stopped cascade counter not cleared");
    a_stop_low: assert property (casc && !lower_run_enable |=> !lower_timer_output)
        else $error("square wave not forced low on stop");
    a_toggle_match: assert property (s_steady ##0 $changed(lower_timer_output)
        |-> lower_match_irq)
        else $error("square wave moved without a match");
    a_start_low: assert property ($rose(lower_output_enable) |-> !lower_timer_output)
        else $error("output not low when enabled");
    a_nrz_gate: assert property (carr && !ctl_rdata[0] |-> !lower_timer_output)
        else $error("carrier passed while nrz bit low");
    a_nrz_reload: assert property (s_reload |=> ctl_rdata[0] == $past(ctl_rdata[1]))
        else $error("nrz bit not reloaded on upper irq");
    a_pwm_clear: assert property (pwm && lower_match_irq |-> lower_counter == 8'h00)
        else $error("pwm match did not clear counter");
    a_upper_pin_off: assert property (casc |-> !upper_timer_output_oe)
        else $error("upper pin enabled in cascade mode");
endmodule
bind cascaded_timer_carrier_pwm cascaded_timer_carrier_pwm_sva i_sva (
    .clk, .rst_n, .mode_sel, .lower_run_enable, .lower_output_enable, .ctl_rdata,
    .upper_counter, .lower_counter, .upper_match_irq, .lower_match_irq,
    .upper_timer_output_oe, .lower_timer_output);
`default_nettype wire

// *** tmr_far_model.sv ***
// partner: event pulse source and load on the timer output pin
`timescale 1ns/10ps
`default_nettype none
module tmr_far_model (
    input  wire logic clk,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      event_pin,
    output logic      pin_level
);
    // ----------------------------------------
    // pin load and event source
    // ----------------------------------------
    // a released output pin sits at the board pull-up
    assign pin_level = pin_oe ? pin_out : 1'b1;
    initial event_pin = 1'b0;
    // pulses wide enough for the two-flop synchroniser
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            #1 event_pin = 1'b1;
            repeat (4) @(posedge clk);
            #1 event_pin = 1'b0;
        end
    endtask
    task automatic level(input logic v);
        @(posedge clk);
        #1 event_pin = v;
    endtask
endmodule
`default_nettype wire

// *** tb_cascaded_timer_carrier_pwm.sv ***
// testbench: directed scenarios for the cascaded timer pair
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_cascaded_timer_carrier_pwm;
    logic       clk, rst_n, ctl_we, upper_run_enable, lower_run_enable;
    logic       upper_output_enable, lower_output_enable, event_input_pin;
    logic [1:0] mode_sel;
    logic [2:0] clock_select;
    logic [7:0] upper_compare, lower_compare_low, lower_compare_high, ctl_wdata;
    logic [7:0] ctl_rdata, upper_counter, lower_counter;
    logic       upper_match_irq, lower_match_irq, lower_timer_output;
    logic       lower_timer_output_oe, compare_high_active, pin_level;
    logic       upper_timer_output, upper_timer_output_oe;
    int         mismatches = 0, total_checks = 0, cycles = 0;
    // ----------------------------------------
    // instances, clock, tasks
    // ----------------------------------------
    cascaded_timer_carrier_pwm i_cascaded_timer_carrier_pwm (.clk, .rst_n, .mode_sel,
        .clock_select, .upper_run_enable, .lower_run_enable, .upper_output_enable,
        .lower_output_enable, .upper_compare, .lower_compare_low, .lower_compare_high,
        .ctl_wdata, .ctl_we, .event_input_pin, .ctl_rdata, .upper_counter,
        .lower_counter, .upper_match_irq, .lower_match_irq, .lower_timer_output,
        .lower_timer_output_oe, .upper_timer_output, .upper_timer_output_oe,
        .compare_high_active);
    tmr_far_model i_tmr_far_model (.clk, .pin_out(lower_timer_output),
        .pin_oe(lower_timer_output_oe), .event_pin(event_input_pin), .pin_level);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_irq(input bit up);
        int k;
        k = 0;
        while ((up ? upper_match_irq : lower_match_irq) !== 1'b1 && k < 3000) begin
            step(1);
            k++;
        end
        `CHK("irq seen", 1'b1, (up ? upper_match_irq : lower_match_irq))
    endtask
    task automatic period(output int c);
        wait_irq(0);
        c = 0;
        do begin
            step(1);
            c++;
        end while (lower_match_irq !== 1'b1 && c < 3000);
    endtask
    task automatic run_len(output int c);
        logic v;
        v = lower_timer_output;
        c = 0;
        while (lower_timer_output === v && c < 3000) begin
            step(1);
            c++;
        end
    endtask
    task automatic wr_ctl(input logic [7:0] v);
        ctl_wdata = v;
        ctl_we = 1'b1;
        step(1);
        ctl_we = 1'b0;
    endtask
    // stop and disable first, configure, enable the pin, run last
    task automatic cfg(input logic [1:0] m, input logic [2:0] cs, input logic [7:0] u, l, h);
        upper_run_enable = 1'b0;
        lower_run_enable = 1'b0;
        lower_output_enable = 1'b0;
        upper_output_enable = 1'b0;
        step(2);
        mode_sel = m;
        clock_select = cs;
        upper_compare = u;
        lower_compare_low = l;
        lower_compare_high = h;
        lower_output_enable = 1'b1;
        step(1);
        `CHK("start level", 1'b0, lower_timer_output)
    endtask
    task automatic t_cascade;
        int c;
        logic o;
        cfg(tmr_pkg::MODE_CASCADE, tmr_pkg::CLK_DIV4, 8'h01, 8'h00, 8'h00);
        lower_run_enable = 1'b1;
        period(c);
        `CHK("16 bit period", 1028, c)
        for (int i = 0; i < 2; i++) begin
            cfg(tmr_pkg::MODE_CASCADE, 3'(i), 8'h00, 8'h00, 8'h00);
            upper_run_enable = 1'b1;
            lower_run_enable = 1'b1;
            wait_irq(0);
            o = lower_timer_output;
            period(c);
            `CHK("zero compare period", 4 << i, c)
            `CHK("square toggle", ~o, lower_timer_output)
        end
        if (lower_timer_output !== 1'b1) period(c);
        lower_run_enable = 1'b0;
        step(2);
        `CHK("stop level", 1'b0, lower_timer_output)
        `CHK("stop count", 16'h0000, {upper_counter, lower_counter})
        `CHK("upper pin off", 2'b00, {upper_timer_output, upper_timer_output_oe})
    endtask
    task automatic t_event;
        int n;
        for (int i = 0; i < 4; i++) begin
            n = (i == 0) ? 260 : 16;
            cfg(tmr_pkg::MODE_CASCADE, 3'(i + 2), 8'hff, 8'hff, 8'hff);
            lower_run_enable = 1'b1;
            i_tmr_far_model.pulses(n);
            step(6);
            `CHK("event count", 16'(n >> i), {upper_counter, lower_counter})
        end
        cfg(tmr_pkg::MODE_CASCADE, tmr_pkg::CLK_EXT, 8'hff, 8'hff, 8'hff);
        i_tmr_far_model.level(1'b1);
        step(4);
        lower_run_enable = 1'b1;
        step(6);
        `CHK("gated start", 8'h01, lower_counter)
        i_tmr_far_model.level(1'b0);
    endtask
    task automatic t_pwm;
        int c;
        cfg(tmr_pkg::MODE_PWM, 3'h6, 8'h00, 8'h00, 8'h00);
        lower_run_enable = 1'b1;
        step(20);
        `CHK("no count select", 8'h00, lower_counter)
        cfg(tmr_pkg::MODE_PWM, tmr_pkg::CLK_DIV4, 8'h00, 8'h02, 8'h05);
        lower_run_enable = 1'b1;
        run_len(c);
        `CHK("high compare active", 1'b1, compare_high_active)
        run_len(c);
        `CHK("pwm high width", 24, c)
        run_len(c);
        `CHK("pwm low width", 12, c)
    endtask
    task automatic t_carrier;
        int c;
        cfg(tmr_pkg::MODE_CARRIER, tmr_pkg::CLK_DIV4, 8'h03, 8'h00, 8'h01);
        wr_ctl(8'h02);
        upper_run_enable = 1'b1;
        lower_run_enable = 1'b1;
        wait_irq(1);
        step(2);
        `CHK("nrz loaded", 8'h03, ctl_rdata)
        run_len(c);
        run_len(c);
        `CHK("carrier low width", 4, c)
        run_len(c);
        `CHK("carrier high width", 8, c)
        wr_ctl(8'h01);
        wait_irq(1);
        step(2);
        `CHK("nrz dropped", 8'h00, ctl_rdata)
        step(9);
        `CHK("gated low", 1'b0, pin_level)
        wr_ctl(8'h02);
        upper_run_enable = 1'b0;
        lower_run_enable = 1'b0;
        step(3);
        `CHK("buffer lost", 1'b0, ctl_rdata[tmr_pkg::CTL_NRZBUF_BIT])
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence and hang guard
    // ----------------------------------------
    initial begin
        {rst_n, ctl_we, upper_run_enable, lower_run_enable} = 4'h0;
        {upper_output_enable, lower_output_enable, mode_sel, clock_select} = 7'h00;
        {upper_compare, lower_compare_low, lower_compare_high, ctl_wdata} = 32'h0000_0000;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        step(1);
        t_cascade();
        t_event();
        t_pwm();
        t_carrier();
        report_and_stop();
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
endmodule
`default_nettype wire
